// ---- design/owd_watchdog.sv ----
`timescale 1ns/1ps
`default_nettype none
module owd_watchdog
   import owd_pkg::*;
#(
   parameter logic [31:0] TIMEOUT_DEF = TMO_RST
) (
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_i,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    exp_trig_i,
   input  wire logic [N_CH-1:0][LVL_W-1:0] chan_norm_i,
   input  wire logic [N_PFL-1:0]        pfl_norm_i,
   output owd_chan_t [N_CH-1:0]         chan_o,
   output logic [N_PFL-1:0]             pfl_o,
   output logic                         expired_o,
   output logic                         irq_o
);
   owd_state_t           state_reg;
   logic [31:0]          timeout_reg;
   logic [31:0]          count_reg;
   logic [3:0]           status_reg;
   logic [3:0]           mask_reg;
   owd_mode_t            mode_reg;
   logic [N_CH-1:0]      guard_reg;
   logic [N_PFL-1:0]     pfl_safe_reg;
   logic [N_PFL-1:0]     pfl_guard_reg;
   logic [N_CH-1:0][LVL_W-1:0] lvl_reg;
   logic [2:0]           trig_sync_reg;

   // AXI write: accept address and data in any order, then respond
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        aw_full_reg;
   logic        w_full_reg;
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   wire [7:0]  wr_addr = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_full_reg ? w_data_reg : s_axi_wdata;
   wire [3:0]  wr_strb = w_full_reg ? w_strb_reg : s_axi_wstrb;
   wire wr_fire = (aw_full_reg || aw_take) && (w_full_reg || w_take);
   wire full_word = (wr_strb == 4'hf);
   wire lvl_hit = (wr_addr >= OFF_LVL0) && (wr_addr < 8'(OFF_LVL0 + 4 * N_CH))
                  && (wr_addr[1:0] == 2'b00);
   wire [7:0] lvl_idx = 8'((wr_addr - OFF_LVL0) >> 2);
   wire wr_known = (wr_addr == OFF_CTRL) || (wr_addr == OFF_TIMEOUT)
                   || (wr_addr == OFF_STATUS) || (wr_addr == OFF_MASK)
                   || (wr_addr == OFF_MODE) || (wr_addr == OFF_PFLSAFE) || lvl_hit;
   wire expired = (state_reg == S_EXPIRED);
   // Configuration writes while expired are refused, and so are CTRL arm/kick without clear; STATUS/MASK and other CTRL writes pass
   wire cfg_addr = (wr_addr == OFF_TIMEOUT) || (wr_addr == OFF_MODE)
                   || (wr_addr == OFF_PFLSAFE) || lvl_hit;
   wire wr_ok = wr_fire && wr_known && full_word;
   wire ctrl_wr = wr_ok && (wr_addr == OFF_CTRL);
   wire clear_cmd = ctrl_wr && wr_data[CTRL_CLEAR];
   wire arm_cmd   = ctrl_wr && wr_data[CTRL_ARM];
   wire kick_cmd  = ctrl_wr && wr_data[CTRL_KICK];
   wire refused = wr_ok && expired && !clear_cmd
                  && (cfg_addr || arm_cmd || kick_cmd);
   wire cfg_wr = wr_ok && !expired && cfg_addr;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (wr_fire) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ok && !refused) ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (aw_take) aw_full_reg <= 1'b1;
            if (w_take) w_full_reg <= 1'b1;
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         end
         if (aw_take) aw_addr_reg <= s_axi_awaddr;
         if (w_take) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
      end
   end

   // Trigger pin: three stages, a trigger counts while stages two and three are both high
   wire trig_rise = trig_sync_reg[1] && trig_sync_reg[2];
   wire timed_out = (state_reg == S_RUN) && (timeout_reg != TMO_DISABLE)
                    && (count_reg == 32'h0000_0000);
   wire trig_exp = trig_rise && (state_reg != S_EXPIRED);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_sync_reg <= 3'b000;
         state_reg     <= S_IDLE;
         count_reg     <= 32'h0000_0000;
      end else begin
         trig_sync_reg <= {trig_sync_reg[1:0], exp_trig_i};
         unique case (state_reg)
            S_IDLE: begin
               if (trig_exp) state_reg <= S_EXPIRED;
               else if (arm_cmd || kick_cmd) begin
                  state_reg <= S_RUN;
                  count_reg <= timeout_reg;
               end
            end
            S_RUN: begin
               if (trig_exp || timed_out) state_reg <= S_EXPIRED;
               else if (kick_cmd) count_reg <= timeout_reg;
               else if (timeout_reg != TMO_DISABLE) count_reg <= count_reg - 32'h1;
            end
            S_EXPIRED: begin
               if (clear_cmd) state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // Status: set wins over write-one-to-clear
   wire [3:0] ev_set = {clear_cmd && expired ? 1'b0 : (trig_exp || timed_out),
                        refused, trig_exp, timed_out};
   wire st_wr = wr_ok && (wr_addr == OFF_STATUS);
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_reg    <= 4'h0;
         mask_reg      <= 4'h0;
         timeout_reg   <= 32'h0000_0000;
         mode_reg      <= MODE_NOCHANGE;
         guard_reg     <= '0;
         pfl_safe_reg  <= '0;
         pfl_guard_reg <= '0;
         lvl_reg       <= '0;
      end else begin
         status_reg <= (status_reg & ~(st_wr ? wr_data[3:0] : 4'h0)) | ev_set;
         if (wr_ok && wr_addr == OFF_MASK) mask_reg <= wr_data[3:0];
         if (cfg_wr && wr_addr == OFF_TIMEOUT) timeout_reg <= wr_data;
         if (cfg_wr && wr_addr == OFF_MODE) begin
            mode_reg  <= owd_mode_t'(wr_data[16]);
            guard_reg <= wr_data[N_CH-1:0];
         end
         if (cfg_wr && wr_addr == OFF_PFLSAFE) begin
            pfl_safe_reg  <= wr_data[N_PFL-1:0];
            pfl_guard_reg <= wr_data[16 +: N_PFL];
         end
         if (cfg_wr && lvl_hit) lvl_reg[lvl_idx[1:0]] <= wr_data[LVL_W-1:0];
      end
   end
   // Boot flag set in reset, cleared on the first clock after reset release; timeout_reg is never loaded from it
   logic boot_reg;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) boot_reg <= 1'b1;
      else boot_reg <= 1'b0;
   end
   // (Default timeout is applied by software; TIMEOUT_DEF reads back only for a read accepted on the first edge after reset release)

   // Outputs; no notification path to function line users
   genvar gi;
   generate
      for (gi = 0; gi < N_CH; gi++) begin : g_ch
         wire force_v = expired && guard_reg[gi] && (mode_reg == MODE_VOLTAGE);
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) chan_o[gi] <= '0;
            else begin
               chan_o[gi].forced <= force_v;
               chan_o[gi].level  <= force_v ? lvl_reg[gi] : chan_norm_i[gi];
            end
         end
      end
      for (gi = 0; gi < N_PFL; gi++) begin : g_pfl
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) pfl_o[gi] <= 1'b0;
            else pfl_o[gi] <= (expired && pfl_guard_reg[gi]) ? pfl_safe_reg[gi]
                                                            : pfl_norm_i[gi];
         end
      end
   endgenerate

   assign expired_o = expired;
   assign irq_o = |(status_reg & mask_reg);

   // Read channel
   wire [31:0] tmo_rd = boot_reg ? TIMEOUT_DEF : timeout_reg;
   logic [31:0] rd_mux;
   wire rlvl = (s_axi_araddr >= OFF_LVL0) && (s_axi_araddr < 8'(OFF_LVL0 + 4 * N_CH));
   wire [7:0] r_idx = 8'((s_axi_araddr - OFF_LVL0) >> 2);
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (rlvl) rd_mux = 32'(lvl_reg[r_idx[1:0]]);
      else if (s_axi_araddr == OFF_TIMEOUT) rd_mux = tmo_rd;
      else if (s_axi_araddr == OFF_STATUS) rd_mux = 32'(status_reg);
      else if (s_axi_araddr == OFF_MASK) rd_mux = 32'(mask_reg);
      else if (s_axi_araddr == OFF_MODE) rd_mux = {15'h0, mode_reg, 16'(guard_reg)};
      else if (s_axi_araddr == OFF_PFLSAFE)
         rd_mux = {16'(pfl_guard_reg), 16'(pfl_safe_reg)};
      else if (s_axi_araddr == OFF_COUNT) rd_mux = count_reg;
      else if (s_axi_araddr == OFF_CTRL) rd_mux = {30'h0, state_reg == S_RUN, expired};
   end
   wire r_known = rlvl || s_axi_araddr == OFF_TIMEOUT || s_axi_araddr == OFF_STATUS
                  || s_axi_araddr == OFF_MASK || s_axi_araddr == OFF_MODE
                  || s_axi_araddr == OFF_PFLSAFE || s_axi_araddr == OFF_COUNT
                  || s_axi_araddr == OFF_CTRL;
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= r_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end

   // Channel 0 and line 0 stand for every generated copy
   AST_EXPIRE_ON_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      timed_out |=> expired) else $error("timeout did not expire");
   AST_TRIG_EXPIRES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      trig_rise && !(expired && clear_cmd) |=> expired) else $error("trigger did not expire");
   AST_NO_TMO_WHEN_DISABLED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_reg == S_RUN) && (timeout_reg == TMO_DISABLE) && !trig_rise |=> !expired)
      else $error("disabled timeout fired");
   AST_HOLD_WHEN_DISABLED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_reg == S_RUN) && (timeout_reg == TMO_DISABLE) && !kick_cmd |=> $stable(count_reg))
      else $error("disabled counter moved");
   AST_STAYS_EXPIRED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      expired && !clear_cmd |=> expired) else $error("expiry left without clear");
   AST_CLEAR_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      expired && clear_cmd |=> state_reg == S_IDLE) else $error("clear did not leave expiry");
   AST_ARM_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_reg == S_IDLE) && (arm_cmd || kick_cmd) && !trig_exp
      |=> (state_reg == S_RUN) && (count_reg == $past(timeout_reg)))
      else $error("arm did not load counter");
   AST_RELOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_reg == S_RUN) && kick_cmd && !timed_out && !trig_rise
      |=> count_reg == $past(timeout_reg)) else $error("restart did not reload");
   AST_COUNT_DOWN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (state_reg == S_RUN) && (timeout_reg != TMO_DISABLE) && !kick_cmd && !timed_out
      && !trig_exp |=> count_reg == $past(count_reg) - 32'h1)
      else $error("counter did not step");
   AST_CH_FORCED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      expired && guard_reg[0] && mode_reg == MODE_VOLTAGE
      |=> chan_o[0].forced && chan_o[0].level == $past(lvl_reg[0]))
      else $error("channel not forced");
   AST_CH_UNGUARDED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      expired && !guard_reg[0] |=> !chan_o[0].forced) else $error("unguarded channel forced");
   AST_CH_NORMAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !rst_i && !expired |=> !chan_o[0].forced && chan_o[0].level == $past(chan_norm_i[0]))
      else $error("channel left normal path");
   AST_NOCHANGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      mode_reg == MODE_NOCHANGE |=> !chan_o[0].forced) else $error("no-change forced");
   AST_PFL_SAFE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      expired && pfl_guard_reg[0] |=> pfl_o[0] == $past(pfl_safe_reg[0]))
      else $error("function line not safe");
   AST_PFL_NORMAL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !rst_i && !(expired && pfl_guard_reg[0]) |=> pfl_o[0] == $past(pfl_norm_i[0]))
      else $error("function line not passed through");
   AST_REFUSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      refused |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(timeout_reg))
      else $error("refused op applied");
   AST_REFUSE_CFG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      refused |=> $stable(lvl_reg) && $stable(mode_reg) && $stable(guard_reg)
      && $stable(pfl_safe_reg) && $stable(pfl_guard_reg)) else $error("refused setup applied");
   AST_STRB_SLVERR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_fire && !full_word |=> s_axi_bresp == RESP_SLVERR) else $error("partial write accepted");
endmodule : owd_watchdog
`default_nettype wire

// ---- design/owd_pkg.sv ----
package owd_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned N_CH            = 4;
   localparam int unsigned N_PFL           = 4;
   localparam int unsigned LVL_W           = 16;
   // Default timeout as printed, 100 ms
   localparam int unsigned TMO_MS          = 100;
   localparam longint unsigned TMO_CYC     = (longint'(TMO_MS) * CLK_HZ) / 1000;
   localparam logic [31:0] TMO_DISABLE     = 32'hffff_ffff;
   localparam logic [31:0] TMO_RST         = 32'(TMO_CYC);

   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_TIMEOUT = 8'h04;
   localparam logic [7:0] OFF_STATUS  = 8'h08;
   localparam logic [7:0] OFF_MASK    = 8'h0c;
   localparam logic [7:0] OFF_MODE    = 8'h10;
   localparam logic [7:0] OFF_PFLSAFE = 8'h14;
   localparam logic [7:0] OFF_COUNT   = 8'h18;
   localparam logic [7:0] OFF_LVL0    = 8'h20;

   localparam int unsigned CTRL_ARM   = 0;
   localparam int unsigned CTRL_KICK  = 1;
   localparam int unsigned CTRL_CLEAR = 2;
   localparam int unsigned ST_TMO     = 0;
   localparam int unsigned ST_TRIG    = 1;
   localparam int unsigned ST_REFUSE  = 2;
   localparam int unsigned ST_EXP     = 3;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic {MODE_NOCHANGE, MODE_VOLTAGE} owd_mode_t;
   typedef enum {S_IDLE, S_RUN, S_EXPIRED} owd_state_t;

   typedef struct packed {
      logic [LVL_W-1:0] level;
      logic             forced;
   } owd_chan_t;
endpackage : owd_pkg

// ---- verif/owd_watchdog_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module owd_watchdog_tb_top;
   import owd_pkg::*;
   logic                       sys_clk_i, rst_i, exp_trig_i;
   logic [7:0]                 awaddr, araddr;
   logic                       awvalid, wvalid, bready, arvalid, rready;
   logic                       awready, wready, bvalid, arready, rvalid;
   logic [31:0]                wdata, rdata;
   logic [3:0]                 wstrb, strb_use;
   logic [1:0]                 bresp, rresp;
   logic [N_CH-1:0][LVL_W-1:0] chan_norm_i;
   logic [N_PFL-1:0]           pfl_norm_i, pfl_o;
   owd_chan_t [N_CH-1:0]       chan_o;
   logic                       expired_o, irq_o;
   int                         failures, samples_checked;

   owd_watchdog DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .exp_trig_i(exp_trig_i),
      .chan_norm_i(chan_norm_i), .pfl_norm_i(pfl_norm_i), .chan_o(chan_o),
      .pfl_o(pfl_o), .expired_o(expired_o), .irq_o(irq_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   task automatic results;
      $display("Checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   task automatic give_up;
      failures++;
      results();
   endtask : give_up

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Ready is sampled mid-cycle so the handshake edge is known before it arrives
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int   n;
      logic ta, tw, a1, w1;
      ta = 1'b0;
      tw = 1'b0;
      n = 0;
      @(posedge sys_clk_i);
      awaddr <= a; wdata <= d; wstrb <= strb_use; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge sys_clk_i);
         a1 = awvalid && awready;
         w1 = wvalid && wready;
         @(posedge sys_clk_i);
         if (a1) begin awvalid <= 1'b0; ta = 1'b1; end
         if (w1) begin wvalid <= 1'b0; tw = 1'b1; end
         if (++n > 50) give_up();
      end
      n = 0;
      do begin
         @(negedge sys_clk_i);
         if (++n > 50) give_up();
      end while (bvalid !== 1'b1);
      chk("bresp", 32'(bresp), 32'(er));
      @(posedge sys_clk_i);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er, input string nm);
      int   n;
      logic t;
      n = 0;
      @(posedge sys_clk_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(negedge sys_clk_i);
         t = arready;
         @(posedge sys_clk_i);
         if (++n > 50) give_up();
      end while (t !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(negedge sys_clk_i);
         if (++n > 100) give_up();
      end while (rvalid !== 1'b1);
      chk("rresp", 32'(rresp), 32'(er));
      if (er == RESP_OKAY) chk(nm, rdata & m, e);
      @(posedge sys_clk_i);
      rready <= 1'b0;
   endtask : rd

   task automatic setup(input logic [31:0] mode, input logic [31:0] tmo);
      for (int i = 0; i < N_CH; i++) axi_wr(OFF_LVL0 + 8'(4*i), 32'ha000 + i, RESP_OKAY);
      axi_wr(OFF_MODE, mode, RESP_OKAY);
      axi_wr(OFF_PFLSAFE, 32'h000f_000a, RESP_OKAY);
      axi_wr(OFF_TIMEOUT, tmo, RESP_OKAY);
      axi_wr(OFF_CTRL, 32'h1, RESP_OKAY);
   endtask : setup

   task automatic wait_exp(input int lo, input int hi, input string nm);
      int n;
      n = 0;
      while (expired_o !== 1'b1) begin
         @(negedge sys_clk_i);
         if (++n > hi) give_up();
      end
      chk(nm, 32'(n >= lo), 32'h1);
   endtask : wait_exp

   task automatic chk_out(input logic volt);
      repeat (3) @(negedge sys_clk_i);
      for (int i = 0; i < N_CH; i++) begin
         chk("chan_forced", 32'(chan_o[i].forced), 32'(volt));
         chk("chan_level", 32'(chan_o[i].level), volt ? 32'ha000 + i : 32'(chan_norm_i[i]));
      end
      chk("pfl_safe", 32'(pfl_o), 32'ha);
   endtask : chk_out

   task automatic clear_exp;
      axi_wr(OFF_CTRL, 32'h4, RESP_OKAY);
      axi_wr(OFF_STATUS, 32'hf, RESP_OKAY);
      repeat (3) @(negedge sys_clk_i);
      chk("expired_cleared", 32'(expired_o), 32'h0);
      chk("chan_released", 32'(chan_o[0].forced), 32'h0);
      chk("pfl_released", 32'(pfl_o), 32'h5);
      chk("irq_cleared", 32'(irq_o), 32'h0);
      rd(OFF_STATUS, 32'hf, 32'h0, RESP_OKAY, "status_w1c");
   endtask : clear_exp

   // Timeout expiry, forced outputs, then refusal while expired
   task automatic s_timeout;
      axi_wr(OFF_MASK, 32'h9, RESP_OKAY);
      setup(32'h0001_000f, 32'd20);
      wait_exp(18, 40, "tmo_latency");
      chk_out(1'b1);
      chk("irq_on", 32'(irq_o), 32'h1);
      rd(OFF_STATUS, 32'h9, 32'h9, RESP_OKAY, "status_tmo");
      axi_wr(OFF_TIMEOUT, 32'd5, RESP_SLVERR);
      axi_wr(OFF_CTRL, 32'h2, RESP_SLVERR);
      axi_wr(OFF_LVL0, 32'h1, RESP_SLVERR);
      repeat (30) @(posedge sys_clk_i);
      chk("still_expired", 32'(expired_o), 32'h1);
      rd(OFF_STATUS, 32'h4, 32'h4, RESP_OKAY, "status_refused");
      rd(OFF_TIMEOUT, 32'hffff_ffff, 32'd20, RESP_OKAY, "tmo_kept");
      clear_exp();
   endtask : s_timeout

   // Restarts inside the interval hold expiry off
   task automatic s_kick;
      setup(32'h0001_000f, 32'd20);
      for (int k = 0; k < 6; k++) begin
         repeat (8) @(posedge sys_clk_i);
         axi_wr(OFF_CTRL, 32'h2, RESP_OKAY);
         chk("kick_alive", 32'(expired_o), 32'h0);
      end
      wait_exp(18, 40, "reload_latency");
      clear_exp();
   endtask : s_kick

   // Timeout disabled; only the trigger pin may expire it
   task automatic s_trig(input logic volt);
      axi_wr(OFF_MASK, 32'h0, RESP_OKAY);
      setup({15'h0, volt, 16'h000f}, TMO_DISABLE);
      repeat (200) @(posedge sys_clk_i);
      chk("no_tmo_expiry", 32'(expired_o), 32'h0);
      rd(OFF_COUNT, 32'hffff_ffff, TMO_DISABLE, RESP_OKAY, "count_held");
      rd(OFF_CTRL, 32'h3, 32'h2, RESP_OKAY, "ctrl_running");
      exp_trig_i <= 1'b1;
      wait_exp(1, 8, "trig_latency");
      @(posedge sys_clk_i);
      exp_trig_i <= 1'b0;
      chk_out(volt);
      chk("irq_masked", 32'(irq_o), 32'h0);
      rd(OFF_STATUS, 32'h2, 32'h2, RESP_OKAY, "status_trig");
      rd(OFF_CTRL, 32'h3, 32'h1, RESP_OKAY, "ctrl_expired");
      clear_exp();
   endtask : s_trig

   initial begin
      failures = 0; samples_checked = 0;
      rst_i = 1'b1; exp_trig_i = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
      strb_use = 4'hf;
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      for (int i = 0; i < N_CH; i++) chan_norm_i[i] = 16'h1000 + 16'(i);
      pfl_norm_i = 4'h5;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(OFF_STATUS, 32'hf, 32'h0, RESP_OKAY, "status_reset");
      axi_wr(8'h1c, 32'h1, RESP_SLVERR);
      rd(8'hfc, 32'h0, 32'h0, RESP_SLVERR, "unmapped");
      // Partial strobes are refused and leave the register alone
      strb_use = 4'h3;
      axi_wr(OFF_MASK, 32'hf, RESP_SLVERR);
      strb_use = 4'hf;
      rd(OFF_MASK, 32'hf, 32'h0, RESP_OKAY, "mask_strb");
      s_timeout();
      s_kick();
      s_trig(1'b1);
      s_trig(1'b0);
      results();
   end
endmodule : owd_watchdog_tb_top
`default_nettype wire
